// [verification/smbus_host_model.sv]
// Purpose: Host side of the link engine: selector loads, word writes, reads.
// Assumes: Every request is a one-cycle pulse answered one cycle later.
// Notes: Missing answers are counted in lost for the bench to judge.
`timescale 1ns/1ps
module smbus_host_model (
    input wire sys_clk_i,
    input wire wr_ack_i,
    input wire reg_rvalid_i,
    input wire [15:0] reg_rdata_i,
    output reg sel_wr_o,
    output reg [7:0] sel_data_o,
    output reg reg_wr_o,
    output reg [15:0] reg_wdata_o,
    output reg reg_rd_o
);
    integer lost;
    integer n;
    reg [7:0] cur;

    // Idle levels before the first request.
    initial
    begin
        lost = 0;
        cur = 8'h00;
        sel_wr_o = 1'b0;
        sel_data_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
        reg_rd_o = 1'b0;
    end

    // Bounded wait, so a dead answer path cannot hang the run.
    task wait_ack(input rd);
    begin
        n = 0;
        @(posedge sys_clk_i);
        while (!(rd ? reg_rvalid_i : wr_ack_i) && n < 8)
        begin
            n = n + 1;
            @(posedge sys_clk_i);
        end
        if (n == 8)
            lost = lost + 1;
    end
    endtask

    // Released data lines show the inverse, never a stale copy.
    task put_sel(input [7:0] a);
    begin
        @(posedge sys_clk_i);
        sel_wr_o <= 1'b1;
        sel_data_o <= a;
        cur = a;
        @(posedge sys_clk_i);
        sel_wr_o <= 1'b0;
        sel_data_o <= ~a;
        wait_ack(1'b0);
    end
    endtask

    // Reserved places are never written; a write there may wedge the part.
    task put_word(input [15:0] d);
    begin
        if (cur < 8'h08 || cur == 8'h22)
        begin
            @(posedge sys_clk_i);
            reg_wr_o <= 1'b1;
            reg_wdata_o <= d;
            @(posedge sys_clk_i);
            reg_wr_o <= 1'b0;
            reg_wdata_o <= ~d;
            wait_ack(1'b0);
        end
    end
    endtask

    // Read data is taken at the edge that shows valid.
    task get_word(output [15:0] d);
    begin
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b0;
        wait_ack(1'b1);
        d = reg_rdata_i;
    end
    endtask
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the thermal sensor register bank.
// Assumes: Identity parameters are set here to arbitrary values.
// Notes: Table of reset reads first, then read-only, window, lock and power-on tests.
`timescale 1ns/1ps
module tb_top;
    localparam [15:0] MAKER = 16'h5a5a; // Arbitrary identity value.
    localparam [15:0] PART = 16'h0c01; // Arbitrary identity value.
    localparam [12:0] U = 13'h0100;
    localparam [12:0] L = 13'h0050;
    localparam integer LIMIT = 5000;
    reg sys_clk_i;
    reg nrst_i;
    reg scl_i;
    reg conv_valid_i;
    reg [12:0] conv_temp_i;
    wire sel_wr;
    wire [7:0] sel_data;
    wire reg_wr;
    wire [15:0] wdata;
    wire reg_rd;
    wire [15:0] rdata;
    wire rvalid;
    wire ack;
    wire [15:0] temp_reg;
    wire alert;
    wire in_reset;
    integer miscompares;
    integer n_compared;
    integer cyc;
    integer i;
    integer h;
    reg [12:0] hv;
    reg [15:0] d;
    reg [23:0] rows [0:11];

    thermal_sensor_register_bank #(.MAKER_ID(MAKER), .PART_ID(PART))
    thermal_sensor_register_bank_i (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sel_wr_i(sel_wr),
        .sel_data_i(sel_data), .reg_wr_i(reg_wr), .reg_wdata_i(wdata), .reg_rd_i(reg_rd),
        .conv_valid_i(conv_valid_i), .conv_temp_i(conv_temp_i), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .wr_ack_o(ack), .sel_o(), .temp_reg_o(temp_reg),
        .alert_o(alert), .in_reset_o(in_reset));

    smbus_host_model smbus_host_model_i (
        .sys_clk_i(sys_clk_i), .wr_ack_i(ack), .reg_rvalid_i(rvalid),
        .reg_rdata_i(rdata), .sel_wr_o(sel_wr), .sel_data_o(sel_data),
        .reg_wr_o(reg_wr), .reg_wdata_o(wdata), .reg_rd_o(reg_rd));

    // Free-running 20 MHz clock.
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Every compare is counted; a mismatch is reported at once.
    task chk(input [15:0] got, input [15:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task wr(input [7:0] a, input [15:0] v);
    begin
        smbus_host_model_i.put_sel(a);
        smbus_host_model_i.put_word(v);
    end
    endtask

    task rd(input [7:0] a, input [15:0] e);
    begin
        smbus_host_model_i.put_sel(a);
        smbus_host_model_i.get_word(d);
        chk(d, e);
    end
    endtask

    // One result, then flags and alert are looked at once they have landed.
    task conv(input [12:0] t, input [1:0] f);
    begin
        @(posedge sys_clk_i);
        conv_valid_i <= 1'b1;
        conv_temp_i <= t;
        @(posedge sys_clk_i);
        conv_valid_i <= 1'b0;
        conv_temp_i <= ~t;
        repeat (4) @(posedge sys_clk_i);
        chk({alert, temp_reg[14:0]}, {|f, f, t});
    end
    endtask

    // Bounded wait for the bank to leave its power-on state.
    task wait_ready;
    begin
        i = 0;
        while (in_reset !== 1'b0 && i < 50)
        begin
            @(posedge sys_clk_i);
            i = i + 1;
        end
        chk({15'h0000, in_reset}, 16'h0000);
    end
    endtask

    task give_verdict;
    begin
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    // Cycle ceiling cuts a hang short.
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end

    initial
    begin
        miscompares = 0;
        n_compared = 0;
        cyc = 0;
        nrst_i = 1'b0;
        scl_i = 1'b1;
        conv_valid_i = 1'b0;
        conv_temp_i = 13'h0000;
        rows[0] = 24'h00_0017;
        rows[1] = 24'h01_0000;
        rows[2] = 24'h02_0000;
        rows[3] = 24'h03_0000;
        rows[4] = 24'h04_0000;
        rows[5] = 24'h22_0000;
        rows[6] = 24'h08_0000;
        rows[7] = 24'h21_0000;
        rows[8] = 24'h23_0000;
        rows[9] = 24'hff_0000;
        rows[10] = {8'h06, MAKER};
        rows[11] = {8'h07, PART};
        repeat (16) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        wait_ready;
        for (h = 0; h < 12; h = h + 1)
            rd(rows[h][23:16], rows[h][15:0]);
        $display("test reset_values done");
        wr(8'h00, 16'hffff);
        rd(8'h00, 16'h0017);
        wr(8'h22, 16'ha5c3);
        rd(8'h22, 16'ha5c3);
        $display("test read_only done");
        // Every hysteresis code is walked through both window edges.
        wr(8'h02, {3'h0, U});
        wr(8'h03, {3'h0, L});
        wr(8'h04, 16'h0400);
        for (h = 0; h < 4; h = h + 1)
        begin
            hv = (h == 0) ? 13'h0000 : (13'h0018 << (h - 1));
            wr(8'h01, {5'h00, h[1:0], 9'h000});
            conv(U + 13'h0001, 2'b10);
            conv(U - hv + 13'h0001, 2'b10);
            conv(U - hv, 2'b00);
            conv(L - hv - 13'h0001, 2'b01);
            conv(L - 13'h0001, 2'b01);
            conv(L, 2'b00);
        end
        // The critical trip drives the alert too, with the 6 C hysteresis still selected.
        wr(8'h04, {3'h0, U});
        conv(U + 13'h0001, 2'b10);
        chk({15'h0000, temp_reg[15]}, 16'h0001);
        conv(L, 2'b00);
        chk({15'h0000, temp_reg[15]}, 16'h0000);
        rd(8'h05, {3'h0, L});
        $display("test window done");
        wr(8'h01, 16'hffff);
        rd(8'h01, 16'h07ff);
        wr(8'h01, 16'h0000);
        rd(8'h01, 16'h00c0);
        wr(8'h02, 16'h0123);
        rd(8'h02, {3'h0, U});
        $display("test locks done");
        // Reset with the clock line held low must not end on its own.
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        scl_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        chk({15'h0000, in_reset}, 16'h0001);
        scl_i <= 1'b1;
        wait_ready;
        rd(8'h01, 16'h0000);
        rd(8'h02, 16'h0000);
        chk(smbus_host_model_i.lost[15:0], 16'h0000);
        $display("test power_on done");
        give_verdict;
    end
endmodule

// [verification/thermal_sensor_monitor.sv]
// Purpose: Concurrent checks on the thermal sensor register bank ports.
// Assumes: Requests arrive only while in_reset_o is low.
// Notes: Attached to the bank by the bind after the module.
`timescale 1ns/1ps
module thermal_sensor_monitor (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire scl_i,
    input wire sel_wr_i,
    input wire [7:0] sel_data_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire conv_valid_i,
    input wire [12:0] conv_temp_i,
    input wire [15:0] reg_rdata_o,
    input wire reg_rvalid_o,
    input wire wr_ack_o,
    input wire [7:0] sel_o,
    input wire [15:0] temp_reg_o,
    input wire alert_o,
    input wire in_reset_o
);
    // One clock domain, so the checks share one clock and one reset.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // A low clock line one edge ago means the power-on state cannot lapse yet.
    sequence scl_held_s;
        !scl_i ##1 in_reset_o;
    endsequence
    sequence conv_s;
        conv_valid_i && !in_reset_o;
    endsequence

    por_hold_a: assert property (scl_held_s |=> in_reset_o)
        else $error("power-on state left while clock line low");
    sel_load_a: assert property (sel_wr_i && !in_reset_o |=>
        wr_ack_o && sel_o == $past(sel_data_i))
        else $error("selector load or ack wrong");
    write_ack_a: assert property (reg_wr_i && !in_reset_o |=> wr_ack_o)
        else $error("word write not acknowledged");
    read_valid_a: assert property (reg_rd_i && !in_reset_o |=> reg_rvalid_o)
        else $error("read data valid missing");
    cap_read_a: assert property (reg_rd_i && !in_reset_o && sel_o == 8'h00 |=>
        reg_rdata_o == 16'h0017)
        else $error("capability word wrong");
    rsvd_read_a: assert property (reg_rd_i && !in_reset_o && sel_o >= 8'h08 &&
        sel_o != 8'h22 |=> reg_rdata_o == 16'h0000)
        else $error("reserved address not zero");
    cfg_read_a: assert property (reg_rd_i && !in_reset_o && sel_o == 8'h01 |=>
        reg_rdata_o[15:11] == 5'h00)
        else $error("configuration upper bits not zero");
    conv_lat_a: assert property (conv_s |-> ##3
        temp_reg_o[12:0] == $past(conv_temp_i, 3))
        else $error("conversion result not latched in time");
    alert_sum_a: assert property (alert_o == (|temp_reg_o[15:13]))
        else $error("alert does not follow the flags");
    // Limit or hysteresis writes alone must never move the pin between conversions.
    alert_move_a: assert property ($changed(alert_o) |-> $past(conv_valid_i, 3))
        else $error("alert moved without a conversion result");
endmodule

bind thermal_sensor_register_bank thermal_sensor_monitor thermal_sensor_monitor_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sel_wr_i(sel_wr_i),
    .sel_data_i(sel_data_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .conv_valid_i(conv_valid_i), .conv_temp_i(conv_temp_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .wr_ack_o(wr_ack_o), .sel_o(sel_o),
    .temp_reg_o(temp_reg_o), .alert_o(alert_o), .in_reset_o(in_reset_o));

// [verilog/thermal_sensor_register_bank.v]
// Purpose: Register bank of a module temperature sensor behind a serial
//          link engine that delivers selector bytes and 16-bit words.
// Assumes: All inputs are synchronous to sys_clk_i; the link engine acks.
// Notes:   Alarm flags are re-evaluated on every new conversion result.
`timescale 1ns/1ps
`include "thermal_sensor_regs.vh"
module thermal_sensor_register_bank #(
    // Identity words are arbitrary neutral values.
    parameter [15:0] MAKER_ID = 16'h5a5a,
    parameter [15:0] PART_ID = 16'h0c01
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire scl_i,
    input wire sel_wr_i,
    input wire [7:0] sel_data_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire conv_valid_i,
    input wire [12:0] conv_temp_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_rvalid_o,
    output reg wr_ack_o,
    output reg [7:0] sel_o,
    output reg [15:0] temp_reg_o,
    output reg alert_o,
    output reg in_reset_o
);

    // Sign extension of a 13-bit temperature field to the compare width.
    function [13:0] sext13;
        input [12:0] v;
        begin
            sext13 = {v[12], v};
        end
    endfunction

    // Hysteresis decode from the two-bit selection.
    function [13:0] hyst_of;
        input [1:0] sel;
        begin
            case (sel)
                2'h1: hyst_of = `HYST_1P5;
                2'h2: hyst_of = `HYST_3P0;
                2'h3: hyst_of = `HYST_6P0;
                default: hyst_of = `HYST_OFF;
            endcase
        end
    endfunction

    reg por_q;
    reg [15:0] cfg_q;
    reg [15:0] upper_q;
    reg [15:0] lower_q;
    reg [15:0] crit_q;
    reg [15:0] busctl_q;
    reg [12:0] temp_q;
    reg update_q;
    reg [15:0] cfg_d;
    reg [15:0] rd_mux;
    wire rst_int;
    wire any_lock;
    wire crit_lock;
    wire win_lock;
    wire [13:0] hyst_val;
    wire above_flag;
    wire below_flag;
    wire crit_flag;
    wire [15:0] cap_word;

    // The power-on state is entered by the reset pin and left only once the
    // serial clock has been seen high. An SCL held low at start-up therefore
    // keeps the whole bank in reset, while SCL low during a normal transfer
    // later on has no effect because por_q is already clear.
    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            por_q <= 1'b1;
        end
        else if (scl_i)
        begin
            por_q <= 1'b0;
        end
    end

    assign rst_int = por_q;

    // Reset visibility for the link engine, which must not ack while in reset.
    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            in_reset_o <= 1'b1;
        end
        else
        begin
            in_reset_o <= por_q;
        end
    end

    // The selector has no address of its own and is loaded by the link engine
    // with the first byte after a write address phase.
    always @(posedge sys_clk_i)
    begin
        if (rst_int)
        begin
            sel_o <= 8'h00;
        end
        else if (sel_wr_i)
        begin
            sel_o <= sel_data_i;
        end
    end

    assign crit_lock = cfg_q[`CFG_CRIT_LOCK_BIT];
    assign win_lock = cfg_q[`CFG_WIN_LOCK_BIT];
    assign any_lock = crit_lock | win_lock;
    assign hyst_val = hyst_of(cfg_q[`CFG_HYST_HI:`CFG_HYST_LO]);

    // Next configuration value. Only bits 10 to 0 are stored; the upper bits
    // are masked so they read back as zero. Lock bits freeze each other: once
    // either is set, neither may change until the bank is reset.
    always @*
    begin
        cfg_d = reg_wdata_i & `CFG_WRITABLE_MASK;
        if (any_lock)
        begin
            cfg_d[`CFG_CRIT_LOCK_BIT] = crit_lock;
            cfg_d[`CFG_WIN_LOCK_BIT] = win_lock;
        end
    end

    // Writable registers. A write to a read-only, identity or reserved address
    // falls through every branch and is still acknowledged below.
    always @(posedge sys_clk_i)
    begin
        if (rst_int)
        begin
            cfg_q <= `RST_CONFIG;
            upper_q <= `RST_LIMIT;
            lower_q <= `RST_LIMIT;
            crit_q <= `RST_LIMIT;
            busctl_q <= `RST_BUS_CONTROL;
        end
        else if (reg_wr_i)
        begin
            case (sel_o)
                `ADDR_CONFIG:
                begin
                    cfg_q <= cfg_d;
                end
                `ADDR_UPPER_LIMIT:
                begin
                    if (!win_lock)
                    begin
                        upper_q <= reg_wdata_i;
                    end
                end
                `ADDR_LOWER_LIMIT:
                begin
                    if (!win_lock)
                    begin
                        lower_q <= reg_wdata_i;
                    end
                end
                `ADDR_CRIT_LIMIT:
                begin
                    if (!crit_lock)
                    begin
                        crit_q <= reg_wdata_i;
                    end
                end
                `ADDR_BUS_CONTROL:
                begin
                    busctl_q <= reg_wdata_i;
                end
                default:
                begin
                    cfg_q <= cfg_q;
                end
            endcase
        end
    end

    // Every pointer load and every word write outside the power-on state is acknowledged one cycle later,
    // whether or not the target can store it.
    always @(posedge sys_clk_i)
    begin
        if (rst_int)
        begin
            wr_ack_o <= 1'b0;
        end
        else
        begin
            wr_ack_o <= reg_wr_i | sel_wr_i;
        end
    end

    // Conversion results are latched as they arrive; update_q then lets the
    // flag cells compare the new value against the current limits.
    always @(posedge sys_clk_i)
    begin
        if (rst_int)
        begin
            temp_q <= 13'h0000;
            update_q <= 1'b0;
        end
        else
        begin
            update_q <= conv_valid_i;
            if (conv_valid_i)
            begin
                temp_q <= conv_temp_i;
            end
        end
    end

    // Above-window flag against the upper limit.
    thermal_window_flag #(
        .CLEAR_ON_HIGH(0)
    ) u_above (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_int),
        .update_i(update_q),
        .temp_i(sext13(temp_q)),
        .limit_i(sext13(upper_q[12:0])),
        .hyst_i(hyst_val),
        .flag_o(above_flag)
    );

    // Below-window flag against the lower limit.
    thermal_window_flag #(
        .CLEAR_ON_HIGH(1)
    ) u_below (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_int),
        .update_i(update_q),
        .temp_i(sext13(temp_q)),
        .limit_i(sext13(lower_q[12:0])),
        .hyst_i(hyst_val),
        .flag_o(below_flag)
    );

    // Critical flag, using the same hysteresis as the window.
    thermal_window_flag #(
        .CLEAR_ON_HIGH(0)
    ) u_crit (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_int),
        .update_i(update_q),
        .temp_i(sext13(temp_q)),
        .limit_i(sext13(crit_q[12:0])),
        .hyst_i(hyst_val),
        .flag_o(crit_flag)
    );

    // Temperature register image and the alert pin level. Both follow the
    // flag cells so the pin can never disagree with what a read reports.
    always @(posedge sys_clk_i)
    begin
        if (rst_int)
        begin
            temp_reg_o <= 16'h0000;
            alert_o <= 1'b0;
        end
        else
        begin
            temp_reg_o <= {crit_flag, above_flag, below_flag, temp_q};
            alert_o <= crit_flag | above_flag | below_flag;
        end
    end

    // Capability word built from named fields; all bits are constants.
    assign cap_word = {10'h000,
                       1'b0,
                       2'h2,
                       1'b1,
                       1'b1,
                       1'b1};

    // Read multiplexer. Anything not decoded, the reserved ranges included,
    // returns zero; the selector itself is write-only and has no read path.
    always @*
    begin
        case (sel_o)
            `ADDR_CAPABILITY: rd_mux = cap_word;
            `ADDR_CONFIG: rd_mux = cfg_q & `CFG_WRITABLE_MASK;
            `ADDR_UPPER_LIMIT: rd_mux = upper_q;
            `ADDR_LOWER_LIMIT: rd_mux = lower_q;
            `ADDR_CRIT_LIMIT: rd_mux = crit_q;
            `ADDR_TEMPERATURE: rd_mux = temp_reg_o;
            `ADDR_MAKER_ID: rd_mux = MAKER_ID;
            `ADDR_PART_ID: rd_mux = PART_ID;
            `ADDR_BUS_CONTROL: rd_mux = busctl_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data is registered so the link engine shifts out a stable word
    // even if a conversion lands during the transfer.
    always @(posedge sys_clk_i)
    begin
        if (rst_int)
        begin
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
            begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

endmodule

// [verilog/thermal_sensor_regs.vh]
// Purpose: Register offsets, field positions, reset values and hysteresis
//          steps for the thermal sensor register bank.
// Assumes: Temperatures are two's complement in 1/16 degree C steps.
// Notes:   Included by the bank module file only, not the flag cell; holds definitions only.
`ifndef THERMAL_SENSOR_REGS_VH
`define THERMAL_SENSOR_REGS_VH

// Selector and data widths.
`define SEL_W 8
`define REG_W 16

// Register offsets seen through the register selector.
`define ADDR_CAPABILITY 8'h00
`define ADDR_CONFIG 8'h01
`define ADDR_UPPER_LIMIT 8'h02
`define ADDR_LOWER_LIMIT 8'h03
`define ADDR_CRIT_LIMIT 8'h04
`define ADDR_TEMPERATURE 8'h05
`define ADDR_MAKER_ID 8'h06
`define ADDR_PART_ID 8'h07
`define ADDR_BUS_CONTROL 8'h22

// Reset values.
`define RST_CAPABILITY 16'h0017
`define RST_CONFIG 16'h0000
`define RST_LIMIT 16'h0000
`define RST_BUS_CONTROL 16'h0000

// Capability fields.
`define CAP_HV_STANDOFF_BIT 5
`define CAP_RES_HI 4
`define CAP_RES_LO 3
`define CAP_WIDE_RANGE_BIT 2
`define CAP_ACCURACY_BIT 1
`define CAP_BASIC_BIT 0

// Configuration fields.
`define CFG_WRITABLE_MASK 16'h07ff
`define CFG_HYST_HI 10
`define CFG_HYST_LO 9
`define CFG_CRIT_LOCK_BIT 7
`define CFG_WIN_LOCK_BIT 6

// Temperature register fields.
`define TMP_CRIT_BIT 15
`define TMP_ABOVE_BIT 14
`define TMP_BELOW_BIT 13
`define TMP_VALUE_HI 12
`define TMP_VALUE_MASK 16'h1fff

// Hysteresis selections in 1/16 degree C steps.
`define HYST_OFF 14'h0000
`define HYST_1P5 14'h0018
`define HYST_3P0 14'h0030
`define HYST_6P0 14'h0060

`endif

// [verilog/thermal_window_flag.v]
// Purpose: One alarm flag with hysteresis, updated per conversion result.
// Assumes: Temperature, limit and hysteresis share 14-bit signed 1/16 C units.
// Notes:   CLEAR_ON_HIGH selects the below-window sense of the flag.
`timescale 1ns/1ps
module thermal_window_flag #(
    parameter CLEAR_ON_HIGH = 0
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire update_i,
    input wire signed [13:0] temp_i,
    input wire signed [13:0] limit_i,
    input wire signed [13:0] hyst_i,
    output reg flag_o
);

    wire signed [13:0] release_point;

    // Threshold lowered by the selected hysteresis.
    assign release_point = limit_i - hyst_i;

    // The flag only moves when a new result is latched, so limit writes between
    // conversions never cause a glitch on the alarm.
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            flag_o <= 1'b0;
        end
        else if (update_i)
        begin
            if (CLEAR_ON_HIGH != 0)
            begin
                if (temp_i >= limit_i)
                begin
                    flag_o <= 1'b0;
                end
                else if (temp_i <= release_point)
                begin
                    flag_o <= 1'b1;
                end
            end
            else
            begin
                if (temp_i > limit_i)
                begin
                    flag_o <= 1'b1;
                end
                else if (temp_i <= release_point)
                begin
                    flag_o <= 1'b0;
                end
            end
        end
    end

endmodule
